// *** sim/ars_audio_bus_test.sv ***
// self-checking bench of the audio routing bus
module ars_audio_bus_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ars_pkg::*;
  typedef struct { int k; int r; ars_smp_t d; } ars_row_t;
  logic                       mclk, nrst, lclk, pb, pw, ps, run, lp, pro, con, b;
  logic [N_SAP-1:0]           sap_m, sap_e, ob, ob_oe, ow, ow_oe;
  logic [1:0]                 sdo;
  ars_src_t [N_TX-1:0]        tx_src;
  ars_src_t [N_TAP-1:0]       rt_src;
  logic [N_SPDIF_RX-1:0][1:0] pin_sel;
  ars_osel_t                  osel;
  logic [N_TAP-1:0]           wr, vld;
  ars_smp_t                   wsmp, psmp, got;
  ars_smp_t [N_TAP-1:0]       rsmp;
  logic [3:0]                 pat, sin;
  int                         err_count, cmp_count, n;
  ars_row_t rows [4] = '{'{0, 0, 48'h000001_FFFFFE}, '{1, 1, 48'h800000_7FFFFF},
                         '{2, 2, 48'hABCDEF_012345}, '{2, 0, 48'hFFFFFF_000000}};
  assign sin = lp ? {pat[3:2], con, pro} : pat;
  ars_audio_bus dut (
    .i_mclk(mclk), .i_nrst(nrst), .i_lclk(lclk), .i_sap_master(sap_m), .i_sap_eiaj(sap_e),
    .i_sap_bclk({4{pb}}), .o_sap_bclk(ob), .o_sap_bclk_oe(ob_oe), .i_sap_wclk({4{pw}}),
    .o_sap_wclk(ow), .o_sap_wclk_oe(ow_oe), .i_sap_sdi({3{ps}}), .o_sap_sdo(sdo),
    .i_tx_src(tx_src), .i_rtap_src(rt_src), .i_rx_pin_sel(pin_sel), .i_out_sel(osel),
    .i_wtap_wr(wr), .i_wtap_smp(wsmp), .o_rtap_smp(rsmp), .o_rtap_vld(vld),
    .i_spdif_in(sin), .o_spdif_pro(pro), .o_spdif_con(con)
  );
  ars_codec_model peer (
    .i_run(run), .i_eiaj(sap_e[0]), .i_smp(psmp), .o_bclk(pb), .o_wclk(pw), .o_sdi(ps)
  );
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial
  begin
    lclk = 1'b0;
    #37;
    forever #80 lclk = ~lclk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic summarize();
    $display("compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task automatic wtap(input int k, input ars_smp_t d);
    @(negedge mclk);
    wr[k] = 1'b1;
    wsmp = d;
    @(negedge mclk);
    wr[k] = 1'b0;
  endtask
  // counts read tap pulses from this falling edge on, keeps the last sample
  task automatic grab(input int r, input int cyc);
    repeat (cyc)
    begin
      if (vld[r] === 1'b1)
      begin
        n++;
        got = rsmp[r];
      end
      @(negedge mclk);
    end
  endtask
  task automatic wait_vld(input int r, input int cnt);
    n = 0;
    for (int i = 0; i < 20000 && n < cnt; i++)
      grab(r, 1);
    if (n < cnt)
    begin
      err_count++;
      $display("wrong value at %0t: read tap never answered", $time);
      summarize();
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    nrst = 1'b0;
    sap_m = 4'h2;
    sap_e = 4'h0;
    run = 1'b0;
    lp = 1'b0;
    tx_src = {ars_src_t'(SRC_WTAP0), 3'h0, 3'h0};
    rt_src = '0;
    pin_sel = {2'h1, 2'h0};
    osel = '0;
    wr = '0;
    wsmp = '0;
    psmp = 48'h123456_ABCDEF;
    pat = 4'h5;
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    chk(48'(ob_oe), 48'h2);
    foreach (rows[i])
    begin
      rt_src[rows[i].r] = ars_src_t'(SRC_WTAP0 + rows[i].k);
      wtap(rows[i].k, rows[i].d);
      n = 0;
      grab(rows[i].r, 4);
      chk(48'(n), 48'h1);
      chk(got, rows[i].d);
    end
    // master port: bclk period of four system clocks
    n = 0;
    b = ob[1];
    repeat (16)
    begin
      @(negedge mclk);
      if (ob[1] !== b)
        n++;
      b = ob[1];
    end
    chk(48'(n), 48'h8);
    // slave serial ports in both formats
    rt_src = {3'h2, 3'h1, 3'h0};
    for (int e = 0; e < 2; e++)
    begin
      @(negedge mclk);
      sap_e = e[0] ? 4'hF : 4'h0;
      psmp = e[0] ? 48'hA5C3E1_0F1E2D : 48'h123456_ABCDEF;
      run = 1'b1;
      wait_vld(0, 3);
      chk(rsmp[0], psmp);
      chk(rsmp[1], psmp);
      chk(rsmp[2], psmp);
    end
    // generated iec958 looped back into both receivers
    run = 1'b0;
    lp = 1'b1;
    rt_src = {3'h0, 3'h4, 3'h3};
    wtap(0, 48'h6B2D91_F04A37);
    wait_vld(0, 3);
    chk(rsmp[0], 48'h6B2D91_F04A37);
    wait_vld(1, 1);
    chk(rsmp[1], 48'h6B2D91_F04A37);
    // pass-through of each input pin
    lp = 1'b0;
    for (int p = 0; p < 4; p++)
    begin
      @(negedge mclk);
      osel = {1'b1, 2'(p)};
      pat = p[0] ? 4'hA : 4'h5;
      repeat (8) @(negedge mclk);
      chk(48'({pro, con}), 48'({2{pat[p]}}));
      pat = ~pat;
      repeat (8) @(negedge mclk);
      chk(48'({pro, con}), 48'({2{pat[p]}}));
    end
    // back to back writes to one tap
    rt_src[0] = ars_src_t'(SRC_WTAP0 + 1);
    @(negedge mclk);
    wr[1] = 1'b1;
    wsmp = 48'h111111_222222;
    @(negedge mclk);
    n = (vld[0] === 1'b1) ? 1 : 0;
    wsmp = 48'h333333_444444;
    @(negedge mclk);
    wr[1] = 1'b0;
    grab(0, 4);
    chk(48'(n), 48'h2);
    chk(got, 48'h333333_444444);
    // reset in mid run
    @(negedge mclk);
    nrst = 1'b0;
    repeat (8) @(negedge mclk);
    chk(48'({vld, pro, con, sdo, ob_oe}), 48'h2);
    nrst = 1'b1;
    summarize();
  end
endmodule

// *** sim/ars_codec_model.sv ***
// serial audio source standing in for an external converter in master mode, driving bit and word clock
module ars_codec_model
  import ars_pkg::*;
(
  // control from the bench
  input  wire logic     i_run,
  input  wire logic     i_eiaj,
  input  wire ars_smp_t i_smp,
  // link pins
  output logic          o_bclk,
  output logic          o_wclk,
  output logic          o_sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [SMP_W-1:0] w;
  int               k;
  initial
  begin
    o_bclk = 1'b0;
    o_wclk = 1'b0;
    o_sdi  = 1'b0;
    forever
    begin
      // clock stands still while i_run is low, data line wanders
      if (!i_run)
      begin
        #400 o_sdi = ~o_sdi;
      end
      else
      begin
        for (int c = 0; c < 2; c++)
        begin
          w = c[0] ? i_smp.right : i_smp.left;
          for (k = 0; k < SLOTS_PER_CH; k++)
          begin
            #400 o_bclk = 1'b0; // period 8 mclk, below a third
            if (k == 0)
              o_wclk = c[0] ^ i_eiaj; // far side drives word clock
            o_sdi = ~o_sdi;
            if (!i_eiaj && k >= 1 && k <= SMP_W)
              o_sdi = w[SMP_W-k];
            if (i_eiaj && k >= 32 - SMP_W)
              o_sdi = w[31-k];
            #400 o_bclk = 1'b1;
          end
        end
      end
    end
  end
endmodule

// *** src/ars_audio_bus.sv ***
// audio bus: serial ports, iec958 receivers and transmitter, processor taps
//
// Contract
// - four serial ports, one duplex, three simplex
// - bit clock at most a third of mclk
// - two iec958 receivers, one transmitter
// - selector routes one of four inputs
// - two outputs differ only in channel status
// - output generated or passes an input through
// - receivers feed bus, transmitters read bus
// - each transmitter selects its own source
// - three read taps with own source
// - three write taps act as sources
// - receiver to transmitter without processor
// - bus routing converts between formats
// - serial ports run as master or slave
module ars_audio_bus (
  // system clock and reset
  input  wire logic                                 i_mclk,
  input  wire logic                                 i_nrst,
  // iec958 link clock, one cycle per half cell
  input  wire logic                                 i_lclk,
  // serial port setup
  input  wire logic [ars_pkg::N_SAP-1:0]            i_sap_master,
  input  wire logic [ars_pkg::N_SAP-1:0]            i_sap_eiaj,
  // serial port pins
  input  wire logic [ars_pkg::N_SAP-1:0]            i_sap_bclk,
  output logic [ars_pkg::N_SAP-1:0]                 o_sap_bclk,
  output logic [ars_pkg::N_SAP-1:0]                 o_sap_bclk_oe,
  input  wire logic [ars_pkg::N_SAP-1:0]            i_sap_wclk,
  output logic [ars_pkg::N_SAP-1:0]                 o_sap_wclk,
  output logic [ars_pkg::N_SAP-1:0]                 o_sap_wclk_oe,
  input  wire logic [2:0]                           i_sap_sdi,
  output logic [1:0]                                o_sap_sdo,
  // routing
  input  wire ars_pkg::ars_src_t [ars_pkg::N_TX-1:0]  i_tx_src,
  input  wire ars_pkg::ars_src_t [ars_pkg::N_TAP-1:0] i_rtap_src,
  input  wire logic [ars_pkg::N_SPDIF_RX-1:0][1:0]  i_rx_pin_sel,
  input  wire ars_pkg::ars_osel_t                   i_out_sel,
  // processor taps
  input  wire logic [ars_pkg::N_TAP-1:0]            i_wtap_wr,
  input  wire ars_pkg::ars_smp_t                    i_wtap_smp,
  output ars_pkg::ars_smp_t [ars_pkg::N_TAP-1:0]    o_rtap_smp,
  output logic [ars_pkg::N_TAP-1:0]                 o_rtap_vld,
  // iec958 pins
  input  wire logic [ars_pkg::N_SPDIF_IN-1:0]       i_spdif_in,
  output logic                                      o_spdif_pro,
  output logic                                      o_spdif_con
);
  import ars_pkg::*;

  // ************************************************************
  // serial audio ports
  // ************************************************************
  ars_smp_t [N_SAP-1:0] sap_rx, sap_tx;
  logic [N_SAP-1:0]     sap_vld, sap_take, sdo_w, sdi_w;
  ars_smp_t [N_SRC-1:0] src_q, src_d, ins_smp;
  logic [N_SRC-1:0]     ins_vld;

  assign sdi_w     = {i_sap_sdi[2], i_sap_sdi[1], 1'b0, i_sap_sdi[0]};
  assign o_sap_sdo = sdo_w[1:0];

  for (genvar p = 0; p < N_SAP; p++)
  begin : g_sap
    if (p < 2)
    begin : g_tx
      assign sap_tx[p] = src_q[i_tx_src[p]];
    end
    else
    begin : g_rx_only
      assign sap_tx[p] = '0;
    end
    ars_sap #(
      .HALF     (BCLK_HALF)
    ) u_sap (
      .i_mclk    (i_mclk),
      .i_nrst    (i_nrst),
      .i_master  (i_sap_master[p]),
      .i_eiaj    (i_sap_eiaj[p]),
      .i_bclk    (i_sap_bclk[p]),
      .o_bclk    (o_sap_bclk[p]),
      .o_bclk_oe (o_sap_bclk_oe[p]),
      .i_wclk    (i_sap_wclk[p]),
      .o_wclk    (o_sap_wclk[p]),
      .o_wclk_oe (o_sap_wclk_oe[p]),
      .i_sdi     (sdi_w[p]),
      .o_sdo     (sdo_w[p]),
      .o_rx_smp  (sap_rx[p]),
      .o_rx_vld  (sap_vld[p]),
      .i_tx_smp  (sap_tx[p]),
      .o_tx_take (sap_take[p])
    );
  end

  // ************************************************************
  // bus sources, read taps, transmitter hold
  // ************************************************************
  ars_smp_t [N_SPDIF_RX-1:0] rxl_smp;
  logic [N_SPDIF_RX-1:0]     rxl_tog, rt1_q, rt2_q, rt3_q;
  ars_smp_t [N_TAP-1:0]      rtap_q, rtap_d;
  logic [N_TAP-1:0]          rvld_q, rvld_d;
  ars_smp_t                  hold_q, hold_d;
  logic                      ack_q, ack_d, rq1_q, rq2_q, rq3_q, rq_seen, rqt_q;

  always_comb
  begin
    ins_smp = '0;
    ins_vld = '0;
    ins_smp[0] = sap_rx[0];
    ins_vld[0] = sap_vld[0];
    ins_smp[1] = sap_rx[2];
    ins_vld[1] = sap_vld[2];
    ins_smp[2] = sap_rx[3];
    ins_vld[2] = sap_vld[3];
    for (int r = 0; r < N_SPDIF_RX; r++)
    begin
      ins_smp[SRC_SPDIF0 + r] = rxl_smp[r];
      ins_vld[SRC_SPDIF0 + r] = rt2_q[r] ^ rt3_q[r];
    end
    for (int k = 0; k < N_TAP; k++)
    begin
      ins_smp[SRC_WTAP0 + k] = i_wtap_smp;
      ins_vld[SRC_WTAP0 + k] = i_wtap_wr[k];
    end
    src_d = src_q;
    for (int i = 0; i < N_SRC; i++)
      if (ins_vld[i])
        src_d[i] = ins_smp[i];
    for (int k = 0; k < N_TAP; k++)
    begin
      rvld_d[k] = ins_vld[i_rtap_src[k]];
      rtap_d[k] = rvld_d[k] ? ins_smp[i_rtap_src[k]] : rtap_q[k];
    end
    // selection read only when the link asks for the next frame
    rq_seen = rq2_q ^ rq3_q;
    hold_d  = rq_seen ? src_q[i_tx_src[T_SPDIF]] : hold_q;
    ack_d   = ack_q ^ rq_seen;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      src_q <= '0; rtap_q <= '0; rvld_q <= '0; hold_q <= '0; ack_q <= 1'b0;
      rq1_q <= 1'b0; rq2_q <= 1'b0; rq3_q <= 1'b0;
      rt1_q <= '0; rt2_q <= '0; rt3_q <= '0;
    end
    else
    begin
      src_q <= src_d; rtap_q <= rtap_d; rvld_q <= rvld_d; hold_q <= hold_d; ack_q <= ack_d;
      rq1_q <= rqt_q; rq2_q <= rq1_q; rq3_q <= rq2_q;
      rt1_q <= rxl_tog; rt2_q <= rt1_q; rt3_q <= rt2_q;
    end
  end

  assign o_rtap_smp = rtap_q;
  assign o_rtap_vld = rvld_q;

  // ************************************************************
  // link domain: reset, pins and setup crossing
  // ************************************************************
  logic [1:0]            lrst_q;
  logic                  lrst_n;
  logic [6:0]            cf1_q, cf2_q;
  logic [N_SPDIF_IN-1:0] in1_q, in2_q;
  logic                  ak1_q, ak2_q, ak3_q;
  ars_osel_t             osel;

  assign lrst_n = lrst_q[1];
  assign osel   = cf2_q[2:0];

  // setup is quasi static, bits may land one link cycle apart
  always_ff @(posedge i_lclk)
  begin
    lrst_q <= {lrst_q[0], i_nrst};
    cf1_q  <= {i_rx_pin_sel, i_out_sel};
    cf2_q  <= cf1_q;
    in1_q  <= i_spdif_in;
    in2_q  <= in1_q;
    ak1_q  <= ack_q;
    ak2_q  <= ak1_q;
    ak3_q  <= ak2_q;
  end

  // ************************************************************
  // iec958 receivers
  // ************************************************************
  for (genvar r = 0; r < N_SPDIF_RX; r++)
  begin : g_rx
    ars_rxst_t        st_q, st_d;
    logic [7:0]       sh_q, sh_d;
    logic [5:0]       hc_q, hc_d;
    logic [SMP_W-1:0] wd_q, wd_d, lh_q, lh_d;
    ars_smp_t         smp_q, smp_d;
    logic             tw_q, tw_d, tog_q, tog_d, x, hit, isw;
    logic [4:0]       slot;

    always_comb
    begin
      x     = in2_q[cf2_q[3 + 2 * r +: 2]];
      sh_d  = {sh_q[6:0], x};
      isw   = (sh_d == PRE_W) || (sh_d == ~PRE_W);
      hit   = isw || (sh_d == PRE_B) || (sh_d == ~PRE_B) || (sh_d == PRE_M) || (sh_d == ~PRE_M);
      slot  = hc_q[5:1];
      st_d  = st_q;
      hc_d  = hc_q;
      wd_d  = wd_q;
      lh_d  = lh_q;
      smp_d = smp_q;
      tw_d  = tw_q;
      tog_d = tog_q;
      if (hit)
      begin
        st_d = ARS_RX_DATA;
        hc_d = PRE_LEN;
        tw_d = isw;
      end
      else
      begin
        case (st_q)
          ARS_RX_HUNT: st_d = ARS_RX_HUNT;
          ARS_RX_DATA:
          begin
            hc_d = hc_q + 6'h01;
            if (hc_q[0] && slot >= AUD_SLOT0 && slot <= AUD_SLOT_LAST)
              wd_d = {x ^ sh_q[0], wd_q[SMP_W-1:1]};
            if (hc_q == AUD_END_HALF)
            begin
              if (tw_q)
              begin
                smp_d = '{left: lh_q, right: wd_d};
                tog_d = ~tog_q;
              end
              else
                lh_d = wd_d;
            end
            if (hc_q == HALF_LAST)
              st_d = ARS_RX_HUNT;
          end
          default: st_d = ARS_RX_HUNT;
        endcase
      end
    end

    always_ff @(posedge i_lclk)
    begin
      if (!lrst_n)
      begin
        st_q <= ARS_RX_HUNT; sh_q <= '0; hc_q <= '0; wd_q <= '0; lh_q <= '0;
        smp_q <= '0; tw_q <= 1'b0; tog_q <= 1'b0;
      end
      else
      begin
        st_q <= st_d; sh_q <= sh_d; hc_q <= hc_d; wd_q <= wd_d; lh_q <= lh_d;
        smp_q <= smp_d; tw_q <= tw_d; tog_q <= tog_d;
      end
    end

    assign rxl_smp[r] = smp_q;
    assign rxl_tog[r] = tog_q;
  end

  // ************************************************************
  // iec958 transmitter, two encoders, index 1 professional
  // ************************************************************
  logic [5:0]       hcnt_q, hcnt_d;
  logic [7:0]       fcnt_q, fcnt_d, pat;
  logic             sub_q, sub_d, rqt_d;
  ars_smp_t         frm_q, frm_d, nxt_q, nxt_d;
  logic [1:0]       lvl_q, lvl_d, inv_q, inv_d, par_q, par_d, out_q, out_d, bitv;
  logic [SMP_W-1:0] aud;
  logic [4:0]       tslot;
  logic [31:0]      cs;

  always_comb
  begin
    hcnt_d = hcnt_q + 6'h01;
    sub_d  = sub_q;
    fcnt_d = fcnt_q;
    frm_d  = frm_q;
    rqt_d  = rqt_q;
    nxt_d  = (ak2_q ^ ak3_q) ? hold_q : nxt_q;
    tslot  = hcnt_q[5:1];
    aud    = sub_q ? frm_q.right : frm_q.left;
    pat    = sub_q ? PRE_W : ((fcnt_q == 8'h00) ? PRE_B : PRE_M);
    if (hcnt_q == HALF_LAST)
    begin
      sub_d = ~sub_q;
      if (sub_q)
      begin
        frm_d  = nxt_q;
        fcnt_d = (fcnt_q == FRAME_LAST) ? 8'h00 : fcnt_q + 8'h01;
        rqt_d  = ~rqt_q;
      end
    end
    for (int o = 0; o < 2; o++)
    begin
      cs      = (o == 1) ? CS_PRO : CS_CON;
      bitv[o] = 1'b0;
      if (tslot >= AUD_SLOT0 && tslot <= AUD_SLOT_LAST)
        bitv[o] = aud[5'(tslot - AUD_SLOT0)];
      else if (tslot == SLOT_CS)
        bitv[o] = (fcnt_q < CS_BITS) ? cs[fcnt_q[4:0]] : 1'b0;
      else if (tslot == SLOT_PAR)
        bitv[o] = par_q[o];
      inv_d[o] = inv_q[o];
      par_d[o] = par_q[o];
      if (hcnt_q < PRE_LEN)
      begin
        if (hcnt_q == 6'h00)
          inv_d[o] = lvl_q[o];
        lvl_d[o] = pat[3'(3'h7 - hcnt_q[2:0])] ^ inv_d[o];
        par_d[o] = 1'b0;
      end
      else if (!hcnt_q[0])
        lvl_d[o] = ~lvl_q[o];
      else
      begin
        lvl_d[o] = lvl_q[o] ^ bitv[o];
        if (tslot != SLOT_PAR)
          par_d[o] = par_q[o] ^ bitv[o];
      end
      out_d[o] = osel.pass ? in2_q[osel.pin] : lvl_q[o];
    end
  end

  always_ff @(posedge i_lclk)
  begin
    if (!lrst_n)
    begin
      hcnt_q <= '0; sub_q <= 1'b0; fcnt_q <= '0; frm_q <= '0; nxt_q <= '0; rqt_q <= 1'b0;
      lvl_q <= '0; inv_q <= '0; par_q <= '0; out_q <= '0;
    end
    else
    begin
      hcnt_q <= hcnt_d; sub_q <= sub_d; fcnt_q <= fcnt_d; frm_q <= frm_d; nxt_q <= nxt_d;
      rqt_q <= rqt_d; lvl_q <= lvl_d; inv_q <= inv_d; par_q <= par_d; out_q <= out_d;
    end
  end

  assign o_spdif_pro = out_q[1];
  assign o_spdif_con = out_q[0];

  // ************************************************************
  // checks
  // ************************************************************
  chk_wtap_store: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_wtap_wr[0] |=> src_q[SRC_WTAP0] == $past(i_wtap_smp))
    else $error("write tap sample not on bus");
  chk_rtap_source: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_rtap_vld[0] |-> o_rtap_smp[0] == src_q[$past(i_rtap_src[0])])
    else $error("read tap returned wrong source");
  chk_hold_select: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    rq_seen |=> hold_q == $past(src_q[i_tx_src[T_SPDIF]]) && ack_q != $past(ack_q))
    else $error("transmit hold not from selected source");
  chk_hold_steady: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !rq_seen |=> $stable(hold_q))
    else $error("transmit sample changed inside a frame");
  chk_pass_through: assert property (@(posedge i_lclk) disable iff (!lrst_n)
    (osel.pass && $stable(osel)) |=> o_spdif_con == $past(in2_q[osel.pin]))
    else $error("pass through output wrong");
  chk_pro_con_match: assert property (@(posedge i_lclk) disable iff (!lrst_n)
    (hcnt_q > PRE_LEN && hcnt_q < 6'h3C) |-> $stable(lvl_q[0] ^ lvl_q[1]))
    else $error("outputs differ outside channel status");
  chk_frame_wrap: assert property (@(posedge i_lclk) disable iff (!lrst_n)
    (hcnt_q == HALF_LAST && sub_q) |=> hcnt_q == 6'h00 && !sub_q && rqt_q != $past(rqt_q))
    else $error("frame did not wrap with a request");
endmodule

// *** src/ars_pkg.sv ***
// shared constants and types of the audio routing bus
package ars_pkg;
  localparam int unsigned SMP_W          = 24;
  localparam int unsigned N_SAP          = 4;
  localparam int unsigned N_SRC          = 8;
  localparam int unsigned N_TAP          = 3;
  localparam int unsigned N_TX           = 3;
  localparam int unsigned N_SPDIF_IN     = 4;
  localparam int unsigned N_SPDIF_RX     = 2;
  // transmitter and source indices
  localparam int unsigned T_SPDIF        = 2;
  localparam int unsigned SRC_SPDIF0     = 3;
  localparam int unsigned SRC_WTAP0      = 5;
  // serial port timing: bit clock at most a third of the system clock
  localparam int unsigned BCLK_RATIO_MIN = 3;
  localparam int unsigned BCLK_HALF      = (BCLK_RATIO_MIN + 1) / 2;
  localparam int unsigned SLOTS_PER_CH   = 32;
  localparam int unsigned I2S_MSB        = 30;
  localparam int unsigned EIAJ_MSB       = 23;
  // biphase framing, one link clock cycle per half cell
  localparam logic [5:0]  HALF_LAST      = 6'h3F;
  localparam logic [5:0]  PRE_LEN        = 6'h08;
  localparam logic [5:0]  AUD_END_HALF   = 6'h37;
  localparam logic [4:0]  AUD_SLOT0      = 5'h04;
  localparam logic [4:0]  AUD_SLOT_LAST  = 5'h1B;
  localparam logic [4:0]  SLOT_CS        = 5'h1E;
  localparam logic [4:0]  SLOT_PAR       = 5'h1F;
  localparam logic [7:0]  FRAME_LAST     = 8'hBF;
  localparam logic [7:0]  CS_BITS        = 8'h20;
  localparam logic [7:0]  PRE_B          = 8'hE8;
  localparam logic [7:0]  PRE_M          = 8'hE2;
  localparam logic [7:0]  PRE_W          = 8'hE4;
  localparam logic [31:0] CS_PRO         = 32'h0000_0001;
  localparam logic [31:0] CS_CON         = 32'h0000_0000;

  typedef logic [2:0] ars_src_t;
  typedef struct packed {
    logic [SMP_W-1:0] left;
    logic [SMP_W-1:0] right;
  } ars_smp_t;
  typedef struct packed {
    logic       pass;
    logic [1:0] pin;
  } ars_osel_t;
  typedef enum logic {
    ARS_RX_HUNT = 1'b0,
    ARS_RX_DATA = 1'b1
  } ars_rxst_t;
endpackage

// *** src/ars_sap.sv ***
// one serial audio port, i2s or eiaj, master or slave
module ars_sap #(
  parameter int unsigned HALF = ars_pkg::BCLK_HALF
) (
  // clock and reset
  input  wire logic            i_mclk,
  input  wire logic            i_nrst,
  // mode
  input  wire logic            i_master,
  input  wire logic            i_eiaj,
  // pins
  input  wire logic            i_bclk,
  output logic                 o_bclk,
  output logic                 o_bclk_oe,
  input  wire logic            i_wclk,
  output logic                 o_wclk,
  output logic                 o_wclk_oe,
  input  wire logic            i_sdi,
  output logic                 o_sdo,
  // audio bus
  output ars_pkg::ars_smp_t    o_rx_smp,
  output logic                 o_rx_vld,
  input  wire ars_pkg::ars_smp_t i_tx_smp,
  output logic                 o_tx_take
);
  import ars_pkg::*;

  logic [2:0]       s1_q, s2_q;
  logic [7:0]       div_q, div_d;
  logic [4:0]       nb_q, nb_d;
  logic             mb_q, mb_d, mw_q, mw_d, bp_q, bp_d, wp_q, wp_d;
  logic [31:0]      rsh_q, rsh_d, tsh_q, tsh_d;
  logic [SMP_W-1:0] lh_q, lh_d, word;
  ars_smp_t         th_q, th_d, rx_q, rx_d;
  logic             vld_q, vld_d, sdo_q, sdo_d;
  logic             b_cur, w_cur, rise, fall, wedge, left_end, left_new, take;

  function automatic logic [31:0] place(input logic eiaj, input logic [SMP_W-1:0] x);
    place = eiaj ? {7'h00, x, 1'b0} : {x, 8'h00};
  endfunction

  always_comb
  begin
    b_cur    = i_master ? mb_q : s2_q[0];
    w_cur    = i_master ? mw_q : s2_q[1];
    rise     = b_cur & ~bp_q;
    fall     = ~b_cur & bp_q;
    wedge    = rise & (w_cur != wp_q);
    left_end = i_eiaj ? wp_q : ~wp_q;
    left_new = i_eiaj ? w_cur : ~w_cur;
    word     = i_eiaj ? rsh_q[EIAJ_MSB -: SMP_W] : rsh_q[I2S_MSB -: SMP_W];
    div_d = div_q + 8'h01;
    mb_d  = mb_q;
    mw_d  = mw_q;
    nb_d  = nb_q;
    bp_d  = b_cur;
    wp_d  = wp_q;
    rsh_d = rsh_q;
    tsh_d = tsh_q;
    lh_d  = lh_q;
    th_d  = th_q;
    rx_d  = rx_q;
    vld_d = 1'b0;
    sdo_d = sdo_q;
    take  = 1'b0;
    // master clocks, word clock flips on a falling bit clock
    if (div_q == 8'(HALF - 1))
    begin
      div_d = 8'h00;
      mb_d  = ~mb_q;
      if (mb_q)
      begin
        nb_d = nb_q + 5'h01;
        if (nb_q == 5'(SLOTS_PER_CH - 1))
          mw_d = ~mw_q;
      end
    end
    if (rise)
    begin
      wp_d  = w_cur;
      rsh_d = {rsh_q[30:0], s2_q[2]};
      if (wedge)
      begin
        if (left_end)
          lh_d = word;
        else
        begin
          rx_d  = '{left: lh_q, right: word};
          vld_d = 1'b1;
        end
        if (left_new)
        begin
          take  = 1'b1;
          th_d  = i_tx_smp;
          tsh_d = place(i_eiaj, i_tx_smp.left);
        end
        else
          tsh_d = place(i_eiaj, th_q.right);
      end
    end
    if (fall)
    begin
      sdo_d = tsh_q[31];
      tsh_d = {tsh_q[30:0], 1'b0};
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      s1_q <= '0; s2_q <= '0; div_q <= '0; nb_q <= '0;
      mb_q <= 1'b0; mw_q <= 1'b0; bp_q <= 1'b0; wp_q <= 1'b0;
      rsh_q <= '0; tsh_q <= '0; lh_q <= '0; th_q <= '0; rx_q <= '0;
      vld_q <= 1'b0; sdo_q <= 1'b0;
    end
    else
    begin
      s1_q <= {i_sdi, i_wclk, i_bclk}; s2_q <= s1_q; div_q <= div_d; nb_q <= nb_d;
      mb_q <= mb_d; mw_q <= mw_d; bp_q <= bp_d; wp_q <= wp_d;
      rsh_q <= rsh_d; tsh_q <= tsh_d; lh_q <= lh_d; th_q <= th_d; rx_q <= rx_d;
      vld_q <= vld_d; sdo_q <= sdo_d;
    end
  end

  assign o_bclk    = mb_q;
  assign o_wclk    = mw_q;
  assign o_bclk_oe = i_master;
  assign o_wclk_oe = i_master;
  assign o_sdo     = sdo_q;
  assign o_rx_smp  = rx_q;
  assign o_rx_vld  = vld_q;
  assign o_tx_take = take;

  chk_bclk_spacing: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_master && rise) |=> !rise [*2])
    else $error("bit clock faster than a third of mclk");
  chk_rx_after_edge: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_rx_vld |-> $past(wedge) && o_rx_smp.right == $past(word))
    else $error("receive sample not from a word edge");
endmodule
